/* File: dgc_regs.svh */
// Register offsets, field positions, reset values and level constants
// for the dynamic range gain curve. Levels and gains are in 1/16 dB.
`ifndef DGC_REGS_SVH
`define DGC_REGS_SVH

`define DGC_OFS_MAIN        8'h1d
`define DGC_OFS_LIMITS      8'h1e
`define DGC_OFS_IN_KNEES    8'h20
`define DGC_OFS_OUT_KNEES   8'h21
`define DGC_OFS_LOW_SLOPES  8'h23
`define DGC_OFS_STATUS      8'h24

`define DGC_RST_MAIN        16'h0006
`define DGC_RST_LIMITS      16'h0c05
`define DGC_RST_IN_KNEES    16'h0000
`define DGC_RST_OUT_KNEES   16'h0003
`define DGC_RST_LOW_SLOPES  16'h0000
`define DGC_RST_ZERO        16'h0000

`define DGC_BIT_DYN_EN      7
`define DGC_BIT_GATE_EN     8
`define DGC_BIT_K2_DROP     13
`define DGC_FLD_K2_IN       12:8
`define DGC_FLD_K1_IN       7:2
`define DGC_FLD_K2_OUT      12:8
`define DGC_FLD_K1_OUT      7:3
`define DGC_FLD_UPPER       2:0
`define DGC_FLD_EXPAND      9:8
`define DGC_FLD_LOWER       7:5
`define DGC_FLD_GFLOOR      12:9
`define DGC_FLD_FLOOR       4:2
`define DGC_FLD_CEIL        1:0

`define DGC_MODE_RECORD     4'h0
`define DGC_MODE_PLAYBACK   4'h1

`define DGC_UPPER_ZERO      3'h5
`define DGC_LOWER_ZERO      3'h4
`define DGC_GFLOOR_TOP      4'hc

`define DGC_K1_STEP         24'sh00000c
`define DGC_K2_STEP         24'sh000018
`define DGC_K2_IN_TOP       24'shfffdc0
`define DGC_K2_OUT_TOP      24'shfffe20
`define DGC_DB_0            24'sh000000
`define DGC_DB_6            24'sh000060
`define DGC_DB_12           24'sh0000c0
`define DGC_DB_18           24'sh000120
`define DGC_DB_24           24'sh000180
`define DGC_DB_36           24'sh000240
`define DGC_DB_M12          24'shffff40
`define DGC_DB_M18          24'shfffee0
`define DGC_DB_M24          24'shfffe80
`define DGC_DB_M36          24'shfffdc0

`define DGC_FIFO_WIDTH      17
`define DGC_FIFO_DEPTH      16

`endif

/* File: dgc_pkg.sv */
// Types shared by the gain curve modules.
// Assumes dgc_regs.svh supplies all numeric constants.
package dgc_pkg;
  typedef logic signed [23:0] dgc_lvl_t;
  typedef logic [15:0]        dgc_word_t;
  typedef enum logic {DGC_PATH_RECORD, DGC_PATH_PLAYBACK} dgc_path_e;
  typedef enum logic [1:0] {DGC_RG_UPPER, DGC_RG_LOWER, DGC_RG_GATE} dgc_region_e;
endpackage

/* File: dgc_stream_if.sv */
// Valid/ready stream carrier between the gain curve modules.
// Assumes one clock shared by both ends.
`timescale 1ns/1ps
interface dgc_stream_if #(parameter int W = 17);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

/* File: dgc_fifo.sv */
// Flip-flop FIFO with valid/ready on both sides.
// Assumes synchronous active-high reset on the shared clock.
`timescale 1ns/1ps
module dgc_fifo
  import dgc_pkg::*;
#(
  parameter int W = 17,
  parameter int D = 16
) (
  input  wire logic   i_clk,
  input  wire logic   i_rst,
  dgc_stream_if.snk   s_in,
  dgc_stream_if.src   s_out
);
  localparam int AW = $clog2(D);

  logic [W-1:0]  mem_r [D];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW:0]   count_r;
  logic [AW:0]   count_nxt;
  logic          ready_r;
  logic          push;
  logic          pop;

  assign push        = s_in.valid && ready_r;
  assign pop         = s_out.valid && s_out.ready;
  assign s_in.ready  = ready_r;
  assign s_out.valid = (count_r != '0);
  assign s_out.data  = mem_r[rd_ptr_r];

  always_comb begin
    count_nxt = count_r;
    if (push && !pop) begin
      count_nxt = count_r + 1'b1;
    end else if (pop && !push) begin
      count_nxt = count_r - 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (push) begin
      mem_r[wr_ptr_r] <= s_in.data;
    end
  end

  // Ready is registered so full stays honest without a comb path back
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
      ready_r  <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr_r <= (wr_ptr_r == AW'(D - 1)) ? '0 : wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= (rd_ptr_r == AW'(D - 1)) ? '0 : rd_ptr_r + 1'b1;
      end
      count_r <= count_nxt;
      ready_r <= (count_nxt != (AW + 1)'(D));
    end
  end

  AST_NO_OVERFLOW: assert property (@(posedge i_clk) disable iff (i_rst)
    (count_r == (AW + 1)'(D)) |-> !ready_r)
    else $error("fifo accepts data while full");
endmodule

/* File: dgc_top.sv */
// Static gain curve of the dynamic range controller: knees, slopes,
// noise gate and gain limits, fed by a level stream through a FIFO.
// Assumes input levels are signed 1/16 dB relative to full scale.
// Summary of operation
// - Gain curve applies only while dyn_enable is set; unity gain otherwise.
// - Gain goes to the record or playback path chosen by DSP mode.
// - Above knee1 use upper_slope; between knee1 and gate use lower_slope.
// - Gate disabled: knee2 and expansion ignored, lower_slope everywhere below knee1.
// - Gate region slope from gate_expansion: 1, 2, 4 or 8.
// - knee2_drop_enable steps output down to knee2_out_level; else continuous.
// - knee2_in_level: -36 dB minus 1.5 dB per code.
// - knee1_in_level: 0 dB minus 0.75 dB per code, to -47.25 dB.
// - knee2_out_level: -30 dB minus 1.5 dB per code, only with drop.
// - knee1_out_level: 0 dB minus 0.75 dB per code, to -23.25 dB.
// - upper_slope codes select 1, 1/2, 1/4, 1/8, 1/16, 0.
// - lower_slope codes select 1, 1/2, 1/4, 1/8, 0.
// - Slope 1 keeps gain constant, slope 0 holds output fixed.
// - Full-scale output level derived from knee1 points and upper_slope.
// - Gain held above floor or gate floor, below ceiling.
// - gate_floor_gain: -36 dB plus 6 dB per code, saturating at 36 dB.
// - floor_gain selects 0, -12, -18, -24 or -36 dB.
// - ceiling_gain selects 12, 18, 24 or 36 dB.
`timescale 1ns/1ps
`include "dgc_regs.svh"
module dgc_top
  import dgc_pkg::*;
(
  input  wire logic         I_CLK,
  input  wire logic         I_RST,
  input  wire logic         I_REG_WE,
  input  wire logic         I_REG_RE,
  input  wire logic [7:0]   I_REG_ADDR,
  input  wire logic [15:0]  I_REG_WDATA,
  output logic      [15:0]  O_REG_RDATA,
  input  wire logic [3:0]   I_DSP_MODE,
  input  wire logic         I_IN_VALID,
  input  wire logic         I_IN_PATH,
  input  wire logic [15:0]  I_IN_LEVEL,
  output logic              O_IN_READY,
  output logic              O_GAIN_VALID,
  output logic              O_GAIN_PATH,
  output logic      [15:0]  O_GAIN,
  input  wire logic         I_OUT_READY
);

  ////////////////////////////////////////////////////////////////////////
  // Register file

  dgc_word_t main_r;
  dgc_word_t limits_r;
  dgc_word_t in_knees_r;
  dgc_word_t out_knees_r;
  dgc_word_t low_slopes_r;
  dgc_word_t status_r;
  dgc_word_t rdata_r;

  function automatic dgc_word_t reg_read(input logic [7:0] a,
                                         input dgc_word_t m, input dgc_word_t l,
                                         input dgc_word_t ki, input dgc_word_t ko,
                                         input dgc_word_t ls, input dgc_word_t st);
    dgc_word_t v;
    v = `DGC_RST_ZERO;
    unique case (a)
      `DGC_OFS_MAIN:       v = m;
      `DGC_OFS_LIMITS:     v = l;
      `DGC_OFS_IN_KNEES:   v = ki;
      `DGC_OFS_OUT_KNEES:  v = ko;
      `DGC_OFS_LOW_SLOPES: v = ls;
      `DGC_OFS_STATUS:     v = st;
      default:             v = `DGC_RST_ZERO;
    endcase
    return v;
  endfunction

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      main_r       <= `DGC_RST_MAIN;
      limits_r     <= `DGC_RST_LIMITS;
      in_knees_r   <= `DGC_RST_IN_KNEES;
      out_knees_r  <= `DGC_RST_OUT_KNEES;
      low_slopes_r <= `DGC_RST_LOW_SLOPES;
    end else if (I_REG_WE) begin
      if (I_REG_ADDR == `DGC_OFS_MAIN)       main_r       <= I_REG_WDATA;
      if (I_REG_ADDR == `DGC_OFS_LIMITS)     limits_r     <= I_REG_WDATA;
      if (I_REG_ADDR == `DGC_OFS_IN_KNEES)   in_knees_r   <= I_REG_WDATA;
      if (I_REG_ADDR == `DGC_OFS_OUT_KNEES)  out_knees_r  <= I_REG_WDATA;
      if (I_REG_ADDR == `DGC_OFS_LOW_SLOPES) low_slopes_r <= I_REG_WDATA;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      rdata_r <= `DGC_RST_ZERO;
    end else if (I_REG_RE) begin
      rdata_r <= reg_read(I_REG_ADDR, main_r, limits_r, in_knees_r, out_knees_r,
                          low_slopes_r, status_r);
    end
  end
  assign O_REG_RDATA = rdata_r;

  logic       dyn_en;
  logic       gate_en;
  logic       k2_drop;
  logic [2:0] up_code;
  logic [2:0] lo_code;
  logic [1:0] exp_code;
  assign dyn_en   = main_r[`DGC_BIT_DYN_EN];
  assign gate_en  = main_r[`DGC_BIT_GATE_EN];
  assign k2_drop  = out_knees_r[`DGC_BIT_K2_DROP];
  assign up_code  = out_knees_r[`DGC_FLD_UPPER];
  assign lo_code  = low_slopes_r[`DGC_FLD_LOWER];
  assign exp_code = low_slopes_r[`DGC_FLD_EXPAND];

  ////////////////////////////////////////////////////////////////////////
  // Level stream buffering

  dgc_stream_if #(.W(`DGC_FIFO_WIDTH)) in_if ();
  dgc_stream_if #(.W(`DGC_FIFO_WIDTH)) head_if ();

  assign in_if.valid = I_IN_VALID;
  assign in_if.data  = {I_IN_PATH, I_IN_LEVEL};
  assign O_IN_READY  = in_if.ready;

  dgc_fifo #(
    .W (`DGC_FIFO_WIDTH),
    .D (`DGC_FIFO_DEPTH)
  ) u_fifo (
    .i_clk (I_CLK),
    .i_rst (I_RST),
    .s_in  (in_if.snk),
    .s_out (head_if.src)
  );

  logic gain_valid_r;
  logic pop;
  // Output stall reaches the FIFO, which then backs up to the source
  assign head_if.ready = !gain_valid_r || I_OUT_READY;
  assign pop           = head_if.valid && head_if.ready;

  ////////////////////////////////////////////////////////////////////////
  // Curve points and slopes

  // Slope as right shift; reserved codes behave as slope 0
  function automatic dgc_lvl_t upper_apply(input dgc_lvl_t d, input logic [2:0] c);
    return (c < `DGC_UPPER_ZERO) ? (d >>> c) : `DGC_DB_0;
  endfunction

  function automatic dgc_lvl_t lower_apply(input dgc_lvl_t d, input logic [2:0] c);
    return (c < `DGC_LOWER_ZERO) ? (d >>> c) : `DGC_DB_0;
  endfunction

  function automatic dgc_lvl_t code_lvl(input logic [5:0] c);
    return dgc_lvl_t'({18'h0, c});
  endfunction

  dgc_lvl_t k1_in;
  dgc_lvl_t k1_out;
  dgc_lvl_t k2_in;
  dgc_lvl_t k2_out;
  dgc_lvl_t y0_r;
  dgc_lvl_t floor_v;
  dgc_lvl_t gfloor_v;
  dgc_lvl_t ceil_v;

  assign k1_in  = `DGC_DB_0 - code_lvl(in_knees_r[`DGC_FLD_K1_IN]) * `DGC_K1_STEP;
  assign k1_out = `DGC_DB_0 - code_lvl({1'b0, out_knees_r[`DGC_FLD_K1_OUT]}) * `DGC_K1_STEP;
  assign k2_in  = `DGC_K2_IN_TOP
                - code_lvl({1'b0, in_knees_r[`DGC_FLD_K2_IN]}) * `DGC_K2_STEP;
  assign k2_out = `DGC_K2_OUT_TOP
                - code_lvl({1'b0, out_knees_r[`DGC_FLD_K2_OUT]}) * `DGC_K2_STEP;

  // Full-scale output level is derived, never software-written
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      y0_r <= `DGC_DB_0;
    end else begin
      y0_r <= k1_out + upper_apply(`DGC_DB_0 - k1_in, up_code);
    end
  end

  always_comb begin
    unique case (limits_r[`DGC_FLD_FLOOR])
      3'h0:    floor_v = `DGC_DB_0;
      3'h1:    floor_v = `DGC_DB_M12;
      3'h2:    floor_v = `DGC_DB_M18;
      3'h3:    floor_v = `DGC_DB_M24;
      3'h4:    floor_v = `DGC_DB_M36;
      default: floor_v = `DGC_DB_0;
    endcase
  end

  always_comb begin
    unique case (limits_r[`DGC_FLD_CEIL])
      2'h0: ceil_v = `DGC_DB_12;
      2'h1: ceil_v = `DGC_DB_18;
      2'h2: ceil_v = `DGC_DB_24;
      2'h3: ceil_v = `DGC_DB_36;
    endcase
  end

  // Codes past the top saturate at 36 dB
  always_comb begin
    if (limits_r[`DGC_FLD_GFLOOR] >= `DGC_GFLOOR_TOP) begin
      gfloor_v = `DGC_DB_36;
    end else begin
      gfloor_v = `DGC_DB_M36 + code_lvl({2'h0, limits_r[`DGC_FLD_GFLOOR]}) * `DGC_DB_6;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Gain computation for the sample at the FIFO head

  dgc_lvl_t    x;
  dgc_lvl_t    y;
  dgc_lvl_t    y_knee2;
  dgc_lvl_t    g_raw;
  dgc_lvl_t    g_lim;
  dgc_region_e region;
  logic        apply;

  assign x = dgc_lvl_t'($signed(head_if.data[15:0]));

  always_comb begin
    if (x >= k1_in) begin
      region = DGC_RG_UPPER;
    end else if (gate_en && (x < k2_in)) begin
      region = DGC_RG_GATE;
    end else begin
      region = DGC_RG_LOWER;
    end
  end

  // Without the drop, the gate starts where the lower slope ends
  assign y_knee2 = k2_drop ? k2_out : k1_out - lower_apply(k1_in - k2_in, lo_code);

  always_comb begin
    unique case (region)
      DGC_RG_UPPER: y = y0_r + upper_apply(x, up_code);
      DGC_RG_LOWER: y = k1_out - lower_apply(k1_in - x, lo_code);
      DGC_RG_GATE:  y = y_knee2 - ((k2_in - x) <<< exp_code);
    endcase
  end

  assign g_raw = y - x;

  // Ceiling checked last so it wins over a floor set above it
  always_comb begin
    g_lim = g_raw;
    if (region == DGC_RG_GATE) begin
      if (g_lim < gfloor_v) g_lim = gfloor_v;
    end else begin
      if (g_lim < floor_v) g_lim = floor_v;
    end
    if (g_lim > ceil_v) g_lim = ceil_v;
  end

  assign apply = dyn_en &&
                 (((I_DSP_MODE == `DGC_MODE_RECORD) && !head_if.data[16]) ||
                  ((I_DSP_MODE == `DGC_MODE_PLAYBACK) && head_if.data[16]));

  ////////////////////////////////////////////////////////////////////////
  // Output stage

  logic [15:0] gain_r;
  logic        gain_path_r;

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      gain_valid_r <= 1'b0;
    end else if (pop) begin
      gain_valid_r <= 1'b1;
    end else if (I_OUT_READY) begin
      gain_valid_r <= 1'b0;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      gain_r      <= `DGC_RST_ZERO;
      gain_path_r <= 1'b0;
    end else if (pop) begin
      gain_r      <= apply ? g_lim[15:0] : `DGC_RST_ZERO;
      gain_path_r <= head_if.data[16];
    end
  end

  // Last applied gain, visible to software
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      status_r <= `DGC_RST_ZERO;
    end else if (pop && apply) begin
      status_r <= g_lim[15:0];
    end
  end

  assign O_GAIN_VALID = gain_valid_r;
  assign O_GAIN       = gain_r;
  assign O_GAIN_PATH  = gain_path_r;

  ////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_RST);

  sequence s_pop_bypass;
    pop && !apply;
  endsequence

  sequence s_unity_out;
    O_GAIN_VALID && (O_GAIN == `DGC_RST_ZERO);
  endsequence

  AST_DISABLED_UNITY: assert property (
    (pop && !dyn_en) |=> s_unity_out)
    else $error("gain not unity while disabled");

  AST_PATH_BYPASS: assert property (
    s_pop_bypass |=> s_unity_out ##0 (O_GAIN_PATH == $past(head_if.data[16])))
    else $error("unselected path received gain");

  AST_CEILING: assert property (
    pop |=> ($signed(O_GAIN) <= $signed($past(ceil_v[15:0]))) || (O_GAIN == `DGC_RST_ZERO))
    else $error("gain above ceiling");

  AST_FLOOR: assert property (
    (pop && apply && (region != DGC_RG_GATE) && (floor_v <= ceil_v))
      |=> ($signed(O_GAIN) >= $signed($past(floor_v[15:0]))))
    else $error("gain below floor");

  AST_GATE_OFF: assert property (
    !gate_en |-> (region != DGC_RG_GATE))
    else $error("gate region used with gate disabled");

  AST_UNITY_SLOPE: assert property (
    (region == DGC_RG_UPPER && up_code == 3'h0 && $stable(out_knees_r)
      && $stable(in_knees_r)) |-> (g_raw == k1_out - k1_in))
    else $error("slope one does not hold gain constant");

  AST_KNEE2_DROP: assert property (
    (region == DGC_RG_GATE && k2_drop) |-> (y + ((k2_in - x) <<< exp_code) == k2_out))
    else $error("gate region not anchored to knee2 output");

  AST_GATE_CONTINUOUS: assert property (
    (region == DGC_RG_GATE && !k2_drop && exp_code == 2'h0)
      |-> (g_raw == k1_out - lower_apply(k1_in - k2_in, lo_code) - k2_in))
    else $error("unity expansion not continuous with lower slope");

  AST_HOLD_STALL: assert property (
    (O_GAIN_VALID && !I_OUT_READY) |=> (O_GAIN_VALID && $stable(O_GAIN)))
    else $error("output changed under stall");
endmodule

/* File: dgc_gain_sink.sv */
// Gain consumer standing downstream of the gain curve.
// Assumes the shared clock and synchronous active-high reset.
`timescale 1ns/1ps
module dgc_gain_sink
  import dgc_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic        i_valid,
  input  wire logic        i_path,
  input  wire logic [15:0] i_gain,
  input  wire logic        i_slow,
  input  wire logic        i_hold,
  output logic             o_ready
);
  logic [1:0]  cnt_r;
  logic [16:0] got[$];

  ////////////////////////////////////////////////////////////////////////////
  // Slow mode accepts one gain in four cycles, to stretch the stall
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cnt_r   <= 2'h0;
      o_ready <= 1'b0;
    end else begin
      cnt_r   <= cnt_r + 2'h1;
      o_ready <= !i_hold && (!i_slow || cnt_r == 2'h0);
    end
  end

  always @(posedge i_clk) begin
    if (!i_rst && i_valid && o_ready) begin
      got.push_back({i_path, i_gain});
    end
  end
endmodule

/* File: dynamic_range_gain_curve_test.sv */
// Self-checking bench for the gain curve: registers, regions, limits,
// path choice and buffering, against a reference curve of its own.
// Assumes dgc_gain_sink stands in for the downstream consumer.
`timescale 1ns/1ps
module dynamic_range_gain_curve_test
  import dgc_pkg::*;
();
  logic        clk, rst, we, re, in_valid, in_path, slow, hold;
  logic [7:0]  addr;
  logic [15:0] wdata, level;
  logic [3:0]  mode;
  wire         in_ready, g_valid, g_path, out_ready;
  wire  [15:0] rdata, gain;
  int          bad_count, compares;
  dgc_word_t   r_main, r_lim, r_ki, r_ko, r_ls;
  logic [16:0] eq[$];
  logic [16:0] last_g;

  dgc_top uut (
    .I_CLK       (clk),
    .I_RST       (rst),
    .I_REG_WE    (we),
    .I_REG_RE    (re),
    .I_REG_ADDR  (addr),
    .I_REG_WDATA (wdata),
    .O_REG_RDATA (rdata),
    .I_DSP_MODE  (mode),
    .I_IN_VALID  (in_valid),
    .I_IN_PATH   (in_path),
    .I_IN_LEVEL  (level),
    .O_IN_READY  (in_ready),
    .O_GAIN_VALID(g_valid),
    .O_GAIN_PATH (g_path),
    .O_GAIN      (gain),
    .I_OUT_READY (out_ready)
  );

  dgc_gain_sink far (
    .i_clk  (clk),
    .i_rst  (rst),
    .i_valid(g_valid),
    .i_path (g_path),
    .i_gain (gain),
    .i_slow (slow),
    .i_hold (hold),
    .o_ready(out_ready)
  );

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  function automatic int sl(input int v, input int c, input int z);
    return (c >= z) ? 0 : (v >>> c);
  endfunction

  function automatic logic [16:0] ref_gain(input logic p, input int x);
    int k1i, k1o, k2i, k2o, y, g, lo_g, hi_g, f, c;
    k1i = -12 * int'(r_ki[7:2]);
    k1o = -12 * int'(r_ko[7:3]);
    k2i = -576 - 24 * int'(r_ki[12:8]);
    k2o = -480 - 24 * int'(r_ko[12:8]);
    f = int'(r_lim[4:2]);
    c = int'(r_lim[1:0]);
    lo_g = (f == 0 || f > 4) ? 0 : (f == 4 ? -576 : -96 * (f + 1));
    hi_g = (c == 3) ? 576 : 96 * (c + 2);
    if (x >= k1i) begin
      y = k1o + sl(-k1i, int'(r_ko[2:0]), 5) + sl(x, int'(r_ko[2:0]), 5);
    end else if (r_main[8] && x < k2i) begin
      y = r_ko[13] ? k2o : k1o - sl(k1i - k2i, int'(r_ls[7:5]), 4);
      y = y - ((k2i - x) <<< r_ls[9:8]);
      lo_g = -576 + 96 * (r_lim[12:9] > 4'hc ? 12 : int'(r_lim[12:9]));
    end else begin
      y = k1o - sl(k1i - x, int'(r_ls[7:5]), 4);
    end
    g = y - x;
    if (g < lo_g) g = lo_g;
    if (g > hi_g) g = hi_g;
    if (!r_main[7] || mode != {3'h0, p}) g = 0;
    return {p, g[15:0]};
  endfunction

  task automatic check(input logic [16:0] seen, input logic [16:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Lowers the sample strobe too, so no stale sample slips in meanwhile
  task automatic wr(input logic [7:0] a, input dgc_word_t d);
    we <= 1'b1;
    in_valid <= 1'b0;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    we <= 1'b0;
    @(posedge clk);
    case (a)
      8'h1d: r_main = d;
      8'h1e: r_lim = d;
      8'h20: r_ki = d;
      8'h21: r_ko = d;
      8'h23: r_ls = d;
      default: ;
    endcase
  endtask

  task automatic rdchk(input logic [7:0] a, input dgc_word_t exp);
    re <= 1'b1;
    addr <= a;
    @(posedge clk);
    re <= 1'b0;
    @(posedge clk);
    check({1'b0, rdata}, {1'b0, exp});
  endtask

  task automatic send(input logic p, input int x);
    in_valid <= 1'b1;
    in_path <= p;
    level <= x[15:0];
    eq.push_back(ref_gain(p, x));
    for (int n = 0; n < 400; n++) begin
      @(posedge clk);
      if (in_ready === 1'b1) break;
    end
  endtask

  task automatic drain();
    in_valid <= 1'b0;
    for (int n = 0; n < 600 && far.got.size() < eq.size(); n++) @(posedge clk);
    check(17'(far.got.size()), 17'(eq.size()));
    while (eq.size() > 0 && far.got.size() > 0) begin
      last_g = eq.pop_front();
      check(far.got.pop_front(), last_g);
    end
    eq.delete();
    far.got.delete();
    @(posedge clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    logic [7:0] ofs[5];
    dgc_word_t  dflt[5];
    ofs  = '{8'h1d, 8'h1e, 8'h20, 8'h21, 8'h23};
    dflt = '{16'h0006, 16'h0c05, 16'h0000, 16'h0003, 16'h0000};
    for (int i = 0; i < 5; i++) rdchk(ofs[i], dflt[i]);
    rdchk(8'h22, 16'h0000);
    for (int i = 0; i < 5; i++) begin
      wr(ofs[i], 16'hffff);
      rdchk(ofs[i], 16'hffff);
      wr(ofs[i], dflt[i]);
    end
    wr(8'h24, 16'h1234);
    rdchk(8'h24, 16'h0000);
    $display("test regs done");
  endtask

  task automatic t_curve();
    // Upstream high-pass filter taken as enabled whenever control is on
    wr(8'h1d, 16'h0086);
    wr(8'h20, 16'h0028);
    for (int c = 0; c < 8; c++) begin
      wr(8'h21, 16'h0020 | 16'(c));
      send(1'b0, 0);
      send(1'b0, -80);
      send(1'b0, -120);
      send(1'b0, -121);
    end
    wr(8'h20, 16'h00f0);
    send(1'b0, -720);
    send(1'b0, -721);
    drain();
    wr(8'h20, 16'h0028);
    wr(8'h21, 16'h0023);
    for (int lo = 0; lo < 8; lo++) begin
      wr(8'h23, 16'(lo) << 5);
      send(1'b0, -200);
      send(1'b0, -2000);
    end
    drain();
    $display("test curve done");
  endtask

  task automatic t_gate();
    wr(8'h1d, 16'h0186);
    wr(8'h1e, 16'h0005);
    wr(8'h20, 16'h1f28);
    for (int e = 0; e < 4; e++) begin
      for (int d = 0; d < 2; d++) begin
        wr(8'h21, 16'h1f23 | (16'(d) << 13));
        wr(8'h23, 16'(e) << 8);
        send(1'b0, -1319);
        send(1'b0, -1321);
        send(1'b0, -1400);
      end
    end
    drain();
    for (int c = 0; c < 16; c++) begin
      wr(8'h1e, (16'(c) << 9) | 16'h0005);
      send(1'b0, -4000);
    end
    drain();
    $display("test gate done");
  endtask

  task automatic t_limits();
    wr(8'h1d, 16'h0086);
    wr(8'h20, 16'h0000);
    wr(8'h21, 16'h00f0);
    wr(8'h23, 16'h0080);
    for (int f = 0; f < 8; f++) begin
      for (int c = 0; c < 4; c++) begin
        wr(8'h1e, 16'h0c00 | (16'(f) << 2) | 16'(c));
        send(1'b0, 0);
        send(1'b0, -2000);
      end
    end
    drain();
    $display("test limits done");
  endtask

  // Sink stalled: one sample sits in the output stage, sixteen in the FIFO
  task automatic t_fifo();
    wr(8'h1e, 16'h0c05);
    hold <= 1'b1;
    repeat (2) @(posedge clk);
    for (int i = 0; i < 17; i++) send(1'b0, -400 - 10 * i);
    in_valid <= 1'b0;
    @(posedge clk);
    check({16'h0, in_ready}, 17'h0);
    check({16'h0, g_valid}, 17'h1);
    hold <= 1'b0;
    slow <= 1'b1;
    drain();
    slow <= 1'b0;
    rdchk(8'h24, last_g[15:0]);
    $display("test fifo done");
  endtask

  task automatic t_path();
    for (int m = 0; m < 4; m++) begin
      mode <= 4'(m);
      @(posedge clk);
      send(1'b0, -100);
      send(1'b1, -100);
      drain();
    end
    mode <= 4'h1;
    wr(8'h1d, 16'h0006);
    send(1'b1, -100);
    send(1'b0, -100);
    drain();
    $display("test path done");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge clk);
    bad_count++;
    end_of_test();
  end

  initial begin
    rst = 1'b1;
    we = 1'b0;
    re = 1'b0;
    in_valid = 1'b0;
    in_path = 1'b0;
    slow = 1'b0;
    hold = 1'b0;
    addr = 8'h00;
    wdata = 16'h0000;
    level = 16'h0000;
    mode = 4'h0;
    bad_count = 0;
    compares = 0;
    r_main = 16'h0006;
    r_lim = 16'h0c05;
    r_ki = 16'h0000;
    r_ko = 16'h0003;
    r_ls = 16'h0000;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_regs();
    t_curve();
    t_gate();
    t_limits();
    t_fifo();
    t_path();
    end_of_test();
  end
endmodule
